//--- logic/iws_defs.svh
// Shared constants of the wiper serial slave and its bus master
// Function
// [RULE1] Invalid command: release SDA, wait next start
// [RULE2] Answer only fixed address 0101111
// [RULE3] Every control byte follows a START
// [RULE4] No address pins, internal pattern only
// [RULE5] Never acknowledge general call or its bytes
// [RULE6] Recovery: START, nine ones, START, STOP
// [RULE7] START returns serial machine to address state
// [RULE8] Master NACK after read byte: release, reset
// [RULE9] Write address acks, then ack every byte
// [RULE10] Wiper updates at each byte's ack
// [RULE11] STOP or START mid byte discards it
// [RULE12] Further write bytes overwrite; STOP ends
// [RULE13] Written MSB ignored, seven bits stored
// [RULE14] Read address acked, then bytes shifted out
// [RULE15] Master acks all read bytes but last
// [RULE16] Device drives all read bits, then releases
// [RULE17] Single read ends after first byte
// [RULE18] Read byte is zero plus wiper value
// [RULE19] Device never stretches SCL
// [RULE20] Reset loads wiper with mid scale 3Fh
// [RULE21] Slave only, up to 400 kb/s
`ifndef IWS_DEFS_SVH
`define IWS_DEFS_SVH

`define IWS_SLAVE_ADDR 7'h2f
`define IWS_WIPER_RESET 7'h3f

`define IWS_CLK_HZ 10000000
`define IWS_SCL_HZ 100000
`define IWS_QUARTER_CYC ((`IWS_CLK_HZ + 4 * `IWS_SCL_HZ - 1) / (4 * `IWS_SCL_HZ))

`define IWS_REG_CTRL 5'h00
`define IWS_REG_WDATA 5'h04
`define IWS_REG_STATUS 5'h08
`define IWS_REG_RDATA 5'h0c

`define IWS_CTRL_GO 0
`define IWS_CTRL_RW 1
`define IWS_CTRL_SRST 2
`define IWS_CTRL_ADDR_LSB 8
`define IWS_CTRL_NB_LSB 16

`define IWS_STAT_BUSY 0
`define IWS_STAT_ANACK 1
`define IWS_STAT_DNACK 2

`endif

//--- logic/iws_pkg.sv
// Types of the wiper serial slave and its bus master
package iws_pkg;

   typedef enum logic [2:0] {
      D_IDLE, D_ADDR, D_AACK, D_WDATA, D_WACK, D_RDATA, D_RACK
   } iws_dev_state_e;

   typedef enum logic [1:0] {
      M_IDLE, M_START, M_BYTE, M_STOP
   } iws_mst_state_e;

endpackage

//--- logic/iws_bus_if.sv
// Two-wire bus joining the master and the wiper slave
`timescale 1ns/1ps
interface iws_bus_if;
   logic scl_o;
   logic scl_oe;
   logic m_sda_o;
   logic m_sda_oe;
   logic d_sda_o;
   logic d_sda_oe;
   logic scl;
   logic sda;

   // Open drain with pull-up: any enabled low wins
   assign scl = !(scl_oe && !scl_o);
   assign sda = !((m_sda_oe && !m_sda_o) || (d_sda_oe && !d_sda_o));

   modport dev (input scl, input sda, output d_sda_o, output d_sda_oe);
   modport mst (input sda, output scl_o, output scl_oe, output m_sda_o, output m_sda_oe);
endinterface

//--- logic/iws_device.sv
// Serial slave holding the seven-bit wiper register
`timescale 1ns/1ps
`include "iws_defs.svh"
module iws_device
   import iws_pkg::*;
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // Serial bus
   iws_bus_if.dev BUS,
   // Wiper side
   output logic [6:0] WIPER,
   output logic WROTE,
   output logic ACTIVE
);

   logic [1:0] s1;
   logic [1:0] s2;
   logic [1:0] s3;
   logic [1:0] f;
   logic [1:0] f_d;
   logic scl;
   logic sda;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   logic wr_stb;
   iws_dev_state_e state;
   logic [3:0] cnt;
   logic [7:0] sh;
   logic [7:0] tx;
   logic rw;
   logic sda_low;

   // Three stages; second and third must agree before a level moves
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         s1 <= 2'h3;
         s2 <= 2'h3;
         s3 <= 2'h3;
      end
      else
      begin
         s1 <= {BUS.scl, BUS.sda};
         s2 <= s1;
         s3 <= s2;
      end
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         f <= 2'h3;
         f_d <= 2'h3;
      end
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            if (s2[i] == s3[i])
            begin
               f[i] <= s3[i];
            end
         end
         f_d <= f;
      end
   end

   assign scl = f[1];
   assign sda = f[0];
   assign scl_rise = scl && !f_d[1];
   assign scl_fall = !scl && f_d[1];
   // Both filtered equally, so SDA edges under high SCL are true conditions
   assign start_seen = scl && f_d[1] && f_d[0] && !sda;
   assign stop_seen = scl && f_d[1] && !f_d[0] && sda;

   // Byte complete at its ack slot; a STOP or START earlier never gets here
   assign wr_stb = (state == D_WDATA) && scl_fall && (cnt == 4'h8); // [RULE11]

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         state <= D_IDLE;
         cnt <= 4'h0;
         sh <= 8'h00;
         tx <= 8'h00;
         rw <= 1'b0;
         sda_low <= 1'b0;
      end
      else if (start_seen)
      begin
         state <= D_ADDR; // [RULE7] [RULE3]
         cnt <= 4'h0;
         sda_low <= 1'b0;
      end
      else if (stop_seen)
      begin
         state <= D_IDLE; // [RULE12] [RULE11]
         sda_low <= 1'b0;
      end
      else
      begin
         case (state)
            D_IDLE:
            begin
               sda_low <= 1'b0; // [RULE1]
            end
            D_ADDR:
            begin
               if (scl_rise)
               begin
                  sh <= {sh[6:0], sda};
                  cnt <= cnt + 4'h1;
               end
               else if (scl_fall && cnt == 4'h8)
               begin
                  // General call and any other address fail here
                  if (sh[7:1] == `IWS_SLAVE_ADDR) // [RULE2] [RULE4] [RULE5]
                  begin
                     rw <= sh[0];
                     sda_low <= 1'b1; // [RULE9] [RULE14]
                     state <= D_AACK;
                  end
                  else
                  begin
                     state <= D_IDLE; // [RULE1] [RULE5]
                  end
               end
            end
            D_AACK:
            begin
               if (scl_fall)
               begin
                  cnt <= 4'h0;
                  if (rw)
                  begin
                     tx <= {1'b0, WIPER}; // [RULE18]
                     sda_low <= 1'b1;
                     state <= D_RDATA;
                  end
                  else
                  begin
                     sda_low <= 1'b0;
                     state <= D_WDATA;
                  end
               end
            end
            D_WDATA:
            begin
               if (scl_rise)
               begin
                  sh <= {sh[6:0], sda};
                  cnt <= cnt + 4'h1;
               end
               else if (scl_fall && cnt == 4'h8)
               begin
                  sda_low <= 1'b1; // [RULE9]
                  state <= D_WACK;
               end
            end
            D_WACK:
            begin
               if (scl_fall)
               begin
                  sda_low <= 1'b0;
                  cnt <= 4'h0;
                  state <= D_WDATA; // [RULE12]
               end
            end
            D_RDATA:
            begin
               if (scl_rise)
               begin
                  cnt <= cnt + 4'h1;
               end
               else if (scl_fall)
               begin
                  if (cnt == 4'h8)
                  begin
                     sda_low <= 1'b0; // [RULE16]
                     state <= D_RACK;
                  end
                  else
                  begin
                     tx <= {tx[6:0], 1'b0};
                     sda_low <= !tx[6]; // [RULE16]
                  end
               end
            end
            D_RACK:
            begin
               if (scl_rise)
               begin
                  if (sda)
                  begin
                     state <= D_IDLE; // [RULE8]
                  end
                  else
                  begin
                     state <= D_AACK;
                  end
               end
            end
            default:
            begin
               state <= D_IDLE;
               sda_low <= 1'b0;
            end
         endcase
      end
   end

   // Only the serial machine sees a bus reset; the wiper keeps its value
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         WIPER <= `IWS_WIPER_RESET; // [RULE20]
         WROTE <= 1'b0;
      end
      else
      begin
         WROTE <= wr_stb;
         if (wr_stb)
         begin
            WIPER <= sh[6:0]; // [RULE10] [RULE13]
         end
      end
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         ACTIVE <= 1'b0;
      end
      else
      begin
         ACTIVE <= (state != D_IDLE);
      end
   end

   // SCL is input only: answers fit in the low phase at 400 kb/s
   // [RULE19] [RULE21]
   assign BUS.d_sda_o = 1'b0;
   assign BUS.d_sda_oe = sda_low;

endmodule // iws_device

//--- logic/iws_master.sv
// Bus master driven from Avalon-MM registers
//
// Our own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`include "iws_defs.svh"
module iws_master
   import iws_pkg::*;
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // Avalon-MM slave
   input wire logic [4:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   // Serial bus
   iws_bus_if.mst BUS
);

   logic [4:0] sel;
   logic busy;
   logic wr_ok;
   logic go;
   logic rvalid;
   logic ctrl_rw;
   logic ctrl_srst;
   logic [6:0] ctrl_addr;
   logic [3:0] ctrl_nb;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic addr_nack;
   logic data_nack;
   logic s1;
   logic s2;
   logic s3;
   logic sda_f;
   iws_mst_state_e state;
   logic [7:0] div;
   logic tick;
   logic [1:0] q;
   logic [3:0] bitn;
   logic [8:0] txs;
   logic [8:0] rxs;
   logic [3:0] left;
   logic in_addr;
   logic srst_stage;
   logic scl_low;
   logic sda_low;

   function automatic logic [8:0] data_frame(input logic rd, input logic last,
                                             input logic [7:0] wd);
      data_frame = rd ? {8'hff, last} : {wd, 1'b1}; // [RULE15]
   endfunction

   assign sel = {AVS_ADDRESS[4:2], 2'b00};
   assign busy = (state != M_IDLE);
   // A new command waits until the running one has ended
   assign AVS_WAITREQUEST = (AVS_READ && !rvalid) || (AVS_WRITE && sel == `IWS_REG_CTRL && busy);
   assign wr_ok = AVS_WRITE && !AVS_WAITREQUEST;
   assign go = wr_ok && sel == `IWS_REG_CTRL && AVS_WRITEDATA[`IWS_CTRL_GO];
   assign tick = (div == 8'(`IWS_QUARTER_CYC - 1));

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         ctrl_rw <= 1'b0;
         ctrl_srst <= 1'b0;
         ctrl_addr <= 7'h00;
         ctrl_nb <= 4'h0;
         wdata <= 8'h00;
      end
      else if (wr_ok && sel == `IWS_REG_CTRL)
      begin
         ctrl_rw <= AVS_WRITEDATA[`IWS_CTRL_RW];
         ctrl_srst <= AVS_WRITEDATA[`IWS_CTRL_SRST];
         ctrl_addr <= AVS_WRITEDATA[`IWS_CTRL_ADDR_LSB +: 7];
         ctrl_nb <= AVS_WRITEDATA[`IWS_CTRL_NB_LSB +: 4];
      end
      else if (wr_ok && sel == `IWS_REG_WDATA)
      begin
         wdata <= AVS_WRITEDATA[7:0];
      end
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         rvalid <= 1'b0;
         AVS_READDATA <= 32'h0;
      end
      else
      begin
         rvalid <= AVS_READ && !rvalid;
         case (sel)
            `IWS_REG_CTRL: AVS_READDATA <= {12'h0, ctrl_nb, 1'b0, ctrl_addr, 5'h0, ctrl_srst,
                                            ctrl_rw, 1'b0};
            `IWS_REG_WDATA: AVS_READDATA <= {24'h0, wdata};
            `IWS_REG_STATUS: AVS_READDATA <= {29'h0, data_nack, addr_nack, busy};
            `IWS_REG_RDATA: AVS_READDATA <= {24'h0, rdata};
            default: AVS_READDATA <= 32'h0;
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         s1 <= 1'b1;
         s2 <= 1'b1;
         s3 <= 1'b1;
         sda_f <= 1'b1;
      end
      else
      begin
         s1 <= BUS.sda;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3)
         begin
            sda_f <= s3;
         end
      end
   end

   // Each symbol is four quarter ticks; SDA moves while SCL is high only in START and STOP
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         state <= M_IDLE;
         div <= 8'h00;
         q <= 2'h0;
         bitn <= 4'h0;
         txs <= 9'h1ff;
         rxs <= 9'h000;
         left <= 4'h0;
         in_addr <= 1'b0;
         srst_stage <= 1'b0;
         scl_low <= 1'b0;
         sda_low <= 1'b0;
         rdata <= 8'h00;
         addr_nack <= 1'b0;
         data_nack <= 1'b0;
      end
      else if (state == M_IDLE)
      begin
         div <= 8'h00;
         q <= 2'h0;
         if (go)
         begin
            state <= M_START; // [RULE3]
            srst_stage <= 1'b0;
            addr_nack <= 1'b0;
            data_nack <= 1'b0;
         end
      end
      else
      begin
         div <= tick ? 8'h00 : div + 8'h01;
         if (tick)
         begin
            q <= q + 2'h1;
            case (state)
               M_START:
               begin
                  case (q)
                     2'h0: sda_low <= 1'b0;
                     2'h1: scl_low <= 1'b0;
                     2'h2: sda_low <= 1'b1;
                     default:
                     begin
                        scl_low <= 1'b1;
                        left <= ctrl_nb;
                        bitn <= 4'h0;
                        if (ctrl_srst && srst_stage)
                        begin
                           state <= M_STOP; // [RULE6]
                        end
                        else
                        begin
                           state <= M_BYTE;
                           in_addr <= !ctrl_srst;
                           txs <= ctrl_srst ? 9'h1ff : {ctrl_addr, ctrl_rw, 1'b1}; // [RULE6]
                        end
                     end
                  endcase
               end
               M_BYTE:
               begin
                  case (q)
                     2'h0: sda_low <= !txs[8];
                     2'h1: scl_low <= 1'b0;
                     2'h2: rxs <= {rxs[7:0], sda_f};
                     default:
                     begin
                        scl_low <= 1'b1;
                        txs <= {txs[7:0], 1'b1};
                        bitn <= bitn + 4'h1;
                        if (bitn == 4'h8)
                        begin
                           bitn <= 4'h0;
                           if (ctrl_srst)
                           begin
                              srst_stage <= 1'b1; // [RULE6]
                              state <= M_START;
                           end
                           else if (in_addr)
                           begin
                              in_addr <= 1'b0;
                              if (rxs[0])
                              begin
                                 addr_nack <= 1'b1;
                                 state <= M_STOP;
                              end
                              else if (left == 4'h0)
                              begin
                                 state <= M_STOP;
                              end
                              else
                              begin
                                 txs <= data_frame(ctrl_rw, left == 4'h1, wdata); // [RULE17]
                              end
                           end
                           else
                           begin
                              left <= left - 4'h1;
                              if (ctrl_rw)
                              begin
                                 rdata <= rxs[8:1];
                              end
                              if ((!ctrl_rw && rxs[0]) || left == 4'h1)
                              begin
                                 data_nack <= !ctrl_rw && rxs[0];
                                 state <= M_STOP; // [RULE12] [RULE15]
                              end
                              else
                              begin
                                 txs <= data_frame(ctrl_rw, left == 4'h2, wdata); // [RULE15]
                              end
                           end
                        end
                     end
                  endcase
               end
               M_STOP:
               begin
                  case (q)
                     2'h0: sda_low <= 1'b1;
                     2'h1: scl_low <= 1'b0;
                     2'h2: sda_low <= 1'b0;
                     default: state <= M_IDLE;
                  endcase
               end
               default: state <= M_IDLE;
            endcase
         end
      end
   end

   assign BUS.scl_o = 1'b0;
   assign BUS.scl_oe = scl_low;
   assign BUS.m_sda_o = 1'b0;
   assign BUS.m_sda_oe = sda_low;

endmodule // iws_master

//--- tb/iws_bus_monitor.sv
// Concurrent checks on the two-wire bus between master and wiper slave
`timescale 1ns/1ps
module iws_bus_monitor
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // Bus lines
   input wire logic scl_oe,
   input wire logic d_sda_oe,
   input wire logic scl,
   input wire logic sda
);
   logic scl_q, sda_q, inf, first, rd, mute;
   logic [3:0] cnt;
   logic [3:0] lowc;
   logic [7:0] sh;
   wire srise = scl && !scl_q;
   wire start = scl && scl_q && sda_q && !sda;
   wire stop = scl && scl_q && !sda_q && sda;

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);

   always_ff @(posedge CLK or negedge RST_N)
      if (!RST_N)
      begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         lowc <= 4'h0;
      end
      else
      begin
         scl_q <= scl;
         sda_q <= sda;
         // Cycles since SCL fell, saturating; bounds the slave's answer time
         if (scl)
            lowc <= 4'h0;
         else if (lowc != 4'hf)
            lowc <= lowc + 4'h1;
      end

   // Frame tracker: bit count, first byte, direction, refused frame
   always_ff @(posedge CLK or negedge RST_N)
      if (!RST_N)
      begin
         inf <= 1'b0;
         first <= 1'b0;
         rd <= 1'b0;
         mute <= 1'b0;
         cnt <= 4'h0;
         sh <= 8'h00;
      end
      else if (start)
      begin
         inf <= 1'b1;
         first <= 1'b1;
         mute <= 1'b0;
         cnt <= 4'h0;
      end
      else if (stop)
         inf <= 1'b0;
      else if (srise && cnt == 4'h8)
      begin
         cnt <= 4'h0;
         first <= 1'b0;
         mute <= mute | sda;
         if (first)
            rd <= sh[0];
      end
      else if (srise)
      begin
         cnt <= cnt + 4'h1;
         sh <= {sh[6:0], sda};
      end

   no_stretch_a: assert property ($changed(d_sda_oe) |-> !scl && lowc < 4'hc)
      else $error("slave SDA answer late in the low phase");
   addr_ack_a: assert property (srise && inf && first && cnt == 4'h8 |-> sda == (sh[7:1] != 7'h2f))
      else $error("address acknowledge wrong");
   write_ack_a: assert property (srise && inf && !first && !rd && !mute && cnt == 4'h8 |-> !sda)
      else $error("write byte not acknowledged");
   read_msb_a: assert property (srise && inf && !first && rd && !mute && cnt == 4'h0 |-> !sda)
      else $error("read byte top bit not zero");
   quiet_idle_a: assert property (d_sda_oe |-> inf)
      else $error("slave drives outside a frame");
   refused_quiet_a: assert property (mute |-> !d_sda_oe)
      else $error("slave drives after refusal");
   stable_high_a: assert property (scl && $past(scl) |-> $stable(d_sda_oe))
      else $error("slave SDA moved while SCL high");
   pull_hold_a: assert property ($rose(d_sda_oe) |-> d_sda_oe [*8])
      else $error("slave pull too short");
   pull_bound_a: assert property ($rose(d_sda_oe) |-> ##[1:1000] !d_sda_oe)
      else $error("slave never released SDA");

   cover property (srise && first && cnt == 4'h8 && !sda);
   cover property (mute);
   cover property (srise && rd && !first && cnt == 4'h0);
endmodule // iws_bus_monitor

//--- tb/test_i2c_wiper_slave.sv
// Self-checking bench for the wiper slave and its bus master
`timescale 1ns/1ps
`include "iws_defs.svh"
module test_i2c_wiper_slave;
   logic clk, rst_n, av_rd, av_wr, av_wait, wrote, active, wrote_b, active_b;
   logic scl_pull, sda_pull, ab;
   logic [4:0] av_addr;
   logic [31:0] av_wd, av_rdata, q;
   logic [6:0] wiper, wiper_b;
   logic [7:0] rb;
   int fails, checked, wrote_n;

   iws_bus_if u_iws_bus_if();
   iws_bus_if u_iws_bus_if_b();
   // Second bus: bench bit-bangs a faulty master
   assign u_iws_bus_if_b.scl_o = 1'b0;
   assign u_iws_bus_if_b.m_sda_o = 1'b0;
   assign u_iws_bus_if_b.scl_oe = scl_pull;
   assign u_iws_bus_if_b.m_sda_oe = sda_pull;

   iws_device u_iws_device (.CLK(clk), .RST_N(rst_n), .BUS(u_iws_bus_if), .WIPER(wiper),
      .WROTE(wrote), .ACTIVE(active));
   iws_device u_iws_device_b (.CLK(clk), .RST_N(rst_n), .BUS(u_iws_bus_if_b),
      .WIPER(wiper_b), .WROTE(wrote_b), .ACTIVE(active_b));
   iws_master u_iws_master (.CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(av_addr),
      .AVS_READ(av_rd), .AVS_WRITE(av_wr), .AVS_WRITEDATA(av_wd), .AVS_READDATA(av_rdata),
      .AVS_WAITREQUEST(av_wait), .BUS(u_iws_bus_if));
   iws_bus_monitor u_iws_bus_monitor (.CLK(clk), .RST_N(rst_n), .scl_oe(u_iws_bus_if.scl_oe),
      .d_sda_oe(u_iws_bus_if.d_sda_oe), .scl(u_iws_bus_if.scl), .sda(u_iws_bus_if.sda));

   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   always @(posedge clk)
      if (!rst_n)
         wrote_n <= 0;
      else if (wrote === 1'b1)
         wrote_n <= wrote_n + 1;

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e)
      begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic conclude();
      $display("checked=%0d fails=%0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // One Avalon cycle; wait state and read data taken at one rising edge
   // Leading edge keeps back-to-back calls from reassigning in one step
   task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      av_addr <= a;
      av_wr <= w;
      av_rd <= !w;
      av_wd <= d;
      do
      begin
         @(posedge clk);
         n++;
      end while (av_wait !== 1'b0 && n < 20000);
      q = av_rdata;
      av_rd <= 1'b0;
      av_wr <= 1'b0;
      if (n >= 20000)
      begin
         fails++;
         conclude();
      end
   endtask

   // Start a command, then poll busy; q ends holding STATUS
   task automatic cmd(input logic [3:0] nb, input logic [6:0] a, input logic [2:0] f);
      int n;
      n = 0;
      av(1'b1, `IWS_REG_CTRL, {12'h0, nb, 1'b0, a, 5'h0, f});
      cyc(2);
      do
      begin
         av(1'b0, `IWS_REG_STATUS, 32'h0);
         n++;
      end while (q[`IWS_STAT_BUSY] !== 1'b0 && n < 3000);
      if (n >= 3000)
      begin
         fails++;
         conclude();
      end
   endtask

   task automatic bbit(input logic b, output logic r);
      sda_pull <= !b;
      cyc(25);
      scl_pull <= 1'b0;
      cyc(25);
      r = u_iws_bus_if_b.sda;
      cyc(25);
      scl_pull <= 1'b1;
      cyc(25);
   endtask

   task automatic bbyte(input logic [7:0] d, input logic ak, output logic [7:0] r,
      output logic a);
      for (int i = 7; i >= 0; i--)
         bbit(d[i], r[i]);
      bbit(ak, a);
   endtask

   // Works from idle and as a repeated start
   task automatic bstart();
      sda_pull <= 1'b0;
      cyc(25);
      scl_pull <= 1'b0;
      cyc(25);
      sda_pull <= 1'b1;
      cyc(25);
      scl_pull <= 1'b1;
      cyc(25);
   endtask

   task automatic bstop();
      sda_pull <= 1'b1;
      cyc(25);
      scl_pull <= 1'b0;
      cyc(25);
      sda_pull <= 1'b0;
      cyc(50);
   endtask

   task automatic t_reset();
      chk(32'(wiper), 32'h3f);
      chk(32'(active), 32'h0);
      av(1'b0, 5'h10, 32'h0);
      chk(q, 32'h0);
      $display("test reset done");
   endtask

   task automatic t_write();
      int w0;
      av(1'b1, `IWS_REG_WDATA, 32'hd5);
      w0 = wrote_n;
      cmd(4'h2, 7'h2f, 3'b001);
      chk(32'(q[2:1]), 32'h0);
      chk(32'(wiper), 32'h55);
      chk(32'(wrote_n - w0), 32'h2);
      $display("test write done");
   endtask

   task automatic t_refuse();
      static logic [6:0] bad [4] = '{7'h00, 7'h2e, 7'h6f, 7'h2d};
      av(1'b1, `IWS_REG_WDATA, 32'h01);
      for (int i = 0; i < 4; i++)
      begin
         cmd(4'h1, bad[i], 3'b001);
         chk(32'(q[`IWS_STAT_ANACK]), 32'h1);
         chk(32'(wiper), 32'h55);
      end
      $display("test refuse done");
   endtask

   task automatic t_srst();
      cmd(4'h0, 7'h2f, 3'b101);
      chk(32'(wiper), 32'h55);
      cyc(5);
      chk(32'(active), 32'h0);
      $display("test soft reset done");
   endtask

   // Single byte first, then two; each leaves the wiper value 55h in the read data register
   task automatic t_read();
      cmd(4'h1, 7'h2f, 3'b011);
      chk(32'(q[2:1]), 32'h0);
      av(1'b0, `IWS_REG_RDATA, 32'h0);
      chk(q, 32'h55);
      cmd(4'h2, 7'h2f, 3'b011);
      chk(32'(q[2:1]), 32'h0);
      av(1'b0, `IWS_REG_RDATA, 32'h0);
      chk(q, 32'h55);
      $display("test read done");
   endtask

   task automatic t_link();
      bstart();
      bbyte(8'h5e, 1'b1, rb, ab);
      chk(32'(ab), 32'h0);
      for (int i = 0; i < 4; i++)
         bbit(1'b0, ab);
      bstop();
      chk(32'(wiper_b), 32'h3f);
      bstart();
      bbyte(8'h00, 1'b1, rb, ab);
      chk(32'(ab), 32'h1);
      bbyte(8'h11, 1'b1, rb, ab);
      chk(32'(ab), 32'h1);
      bstop();
      chk(32'(wiper_b), 32'h3f);
      bstart();
      bbyte(8'h5e, 1'b1, rb, ab);
      bbyte(8'h92, 1'b1, rb, ab);
      chk(32'(ab), 32'h0);
      chk(32'(wiper_b), 32'h12);
      bstart();
      bbyte(8'h5f, 1'b1, rb, ab);
      chk(32'(ab), 32'h0);
      bbyte(8'hff, 1'b1, rb, ab);
      chk(32'(rb), 32'h12);
      chk(32'(u_iws_bus_if_b.d_sda_oe), 32'h0);
      chk(32'(active_b), 32'h0);
      bstop();
      $display("test link done");
   endtask

   initial
   begin
      rst_n = 1'b0;
      av_rd = 1'b0;
      av_wr = 1'b0;
      av_addr = 5'h00;
      av_wd = 32'h0;
      scl_pull = 1'b0;
      sda_pull = 1'b0;
      fails = 0;
      checked = 0;
      cyc(20);
      rst_n <= 1'b1;
      cyc(5);
      t_reset();
      t_write();
      t_refuse();
      t_srst();
      t_read();
      t_link();
      conclude();
   end
endmodule // test_i2c_wiper_slave
